// *** bench/espsub_printer.sv ***
// espsub_printer: print decoding model that gathers magnet selections
// assumes clr is pulsed by the bench before each print
`timescale 1ns/1ps
module espsub_printer
(
    // clock and control
    input wire logic ref_clk,
    input wire logic clr,
    // selections
    input wire espsub_pkg::espsub_sel_t print_sel,
    output logic [5:0] seen
);
    always_ff @(posedge ref_clk)
        if (clr) seen <= '0;
        else seen <= seen | print_sel;
endmodule : espsub_printer

// *** bench/espsub_props.sv ***
// espsub_props: timing checks on the error-mark outputs of espsub_top
// assumes a single ref_clk domain with active-low reset_n
`timescale 1ns/1ps
module espsub_props
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // detectors and buffer input
    input wire espsub_pkg::espsub_err_t err_in,
    input wire logic mark_load,
    input wire logic [espsub_pkg::CODE_W-1:0] buf_in,
    input wire logic print_strobe,
    // toward print decoding
    input wire logic [espsub_pkg::CODE_W-1:0] second_char_buffer,
    input wire espsub_pkg::espsub_sel_t print_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire early = err_in.lrc_err | err_in.ovf_err | err_in.rcv_err;
    sequence s_case;
        err_in.case_err ##1 print_strobe;
    endsequence
    property p_early; early |=> second_char_buffer inside {8'hC4, 8'h02}; endproperty
    property p_bits; early |=> second_char_buffer[1] != second_char_buffer[2]; endproperty
    property p_load; mark_load && !early |=> second_char_buffer == $past(buf_in); endproperty
    property p_hold; !mark_load && !early |=> $stable(second_char_buffer); endproperty
    property p_case; s_case |=> print_sel.shift_inhibit; endproperty
    property p_sel; print_sel.shift_inhibit |-> print_sel[5:1] inside {5'h00, 5'h1F}; endproperty
    property p_quiet; !print_strobe |=> print_sel == '0; endproperty
    property p_inh; print_sel != '0 |-> print_sel.shift_inhibit; endproperty
    a_early: assert property (p_early) else $error("wrong mark code");
    a_bits: assert property (p_bits) else $error("mark bits wrong");
    a_load: assert property (p_load) else $error("load altered");
    a_hold: assert property (p_hold) else $error("buffer changed");
    a_case: assert property (p_case) else $error("no case mark");
    a_sel: assert property (p_sel) else $error("partial selects");
    a_quiet: assert property (p_quiet) else $error("stray selects");
    a_inh: assert property (p_inh) else $error("shift not held");
endmodule : espsub_props
bind espsub_top espsub_props espsub_props_i (.ref_clk, .reset_n, .err_in, .mark_load, .buf_in,
    .print_strobe, .second_char_buffer, .print_sel);

// *** bench/espsub_top_tb.sv ***
// espsub_top_tb: register and error-mark tests for espsub_top
// assumes the checker is bound in and the printer model watches print_sel
`timescale 1ns/1ps
module espsub_top_tb;
    logic ref_clk, reset_n, mark_load, print_strobe, irq, clr;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    logic [3:0] s_awaddr, s_araddr, s_wstrb;
    logic [31:0] s_wdata, s_rdata, d;
    logic [1:0] s_bresp, s_rresp, r;
    logic [7:0] buf_in, second_char_buffer;
    logic [5:0] seen;
    espsub_pkg::espsub_err_t err_in;
    espsub_pkg::espsub_sel_t print_sel;
    int mismatches, samples_checked;
    espsub_top espsub_top_i (.ref_clk, .reset_n, .err_in, .mark_load, .buf_in, .print_strobe,
        .second_char_buffer, .print_sel, .irq, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
        .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready,
        .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp);
    espsub_printer espsub_printer_i (.ref_clk, .clr, .print_sel, .seen);
    ////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
        samples_checked++;
        if (seen_v !== exp_v)
        begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
            mismatches++;
        end
    endtask : chk
    task guard(input logic answered);
        if (answered !== 1'b1)
        begin
            mismatches++;
            results();
        end
    endtask : guard
    task wr(input logic [3:0] a, input logic [31:0] v);
        int n;
        @(posedge ref_clk);
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_awaddr <= a;
        s_wdata <= v;
        s_bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            n++;
        end while (!s_bvalid && n < 50);
        s_bready <= 1'b0;
        r = s_bresp;
        guard(s_bvalid);
    endtask : wr
    task rd(input logic [3:0] a);
        int n;
        @(posedge ref_clk);
        s_arvalid <= 1'b1;
        s_araddr <= a;
        s_rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            if (s_arready) s_arvalid <= 1'b0;
            n++;
        end while (!s_rvalid && n < 50);
        s_rready <= 1'b0;
        d = s_rdata;
        r = s_rresp;
        guard(s_rvalid);
    endtask : rd
    task pulse(input logic [3:0] e, input logic ld);
        @(posedge ref_clk);
        err_in <= e;
        mark_load <= ld;
        @(posedge ref_clk);
        err_in <= '0;
        mark_load <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : pulse
    task prt(input logic [3:0] e);
        @(posedge ref_clk);
        clr <= 1'b1;
        err_in <= e;
        @(posedge ref_clk);
        clr <= 1'b0;
        err_in <= '0;
        print_strobe <= 1'b1;
        @(posedge ref_clk);
        print_strobe <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : prt
    ////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        {reset_n, mark_load, print_strobe, s_awvalid, s_wvalid, s_bready} = '0;
        {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata, buf_in, err_in} = '0;
        s_wstrb = 4'hF;
        clr = 1'b1;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(espsub_pkg::OFS_CTRL);
        chk(d, espsub_pkg::CTRL_RESET);
        rd(espsub_pkg::OFS_MASK);
        chk(d, 32'h0);
        rd(4'h2);
        chk(r, espsub_pkg::RESP_SLVERR);
        for (int i = 0; i < 3; i++)
        begin
            pulse(4'h8 >> i, 1'b1);
            chk(second_char_buffer, 8'hC4);
        end
        buf_in <= 8'h3B;
        pulse(4'h0, 1'b1);
        chk(second_char_buffer, 8'h3B);
        prt(4'h1);
        chk(seen, 6'h3F);
        prt(4'h0);
        chk(seen, 6'h00);
        wr(espsub_pkg::OFS_MASK, 32'hF);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b1);
        rd(espsub_pkg::OFS_STATUS);
        chk(d, 32'hF);
        repeat (2) @(posedge ref_clk);
        chk(irq, 1'b0);
        wr(espsub_pkg::OFS_CTRL, 32'h0);
        pulse(4'h8, 1'b0);
        chk(second_char_buffer, 8'h02);
        prt(4'h1);
        chk(seen, 6'h01);
        rd(espsub_pkg::OFS_COUNT);
        chk(d, 32'h6);
        wr(espsub_pkg::OFS_STATUS, 32'hF);
        chk(r, espsub_pkg::RESP_OKAY);
        rd(espsub_pkg::OFS_STATUS);
        chk(d, 32'h9);
        wr(4'h2, 32'h0);
        chk(r, espsub_pkg::RESP_SLVERR);
        results();
    end
endmodule : espsub_top_tb

// *** core/espsub_pkg.sv ***
// espsub_pkg: constants, register map and carrier types for the error-mark substitute block
// assumes a 40 MHz ref_clk and an AXI4-Lite register bus with 32-bit data
package espsub_pkg;

    // character code layout of the second character buffer
    localparam int CODE_W = 8;
    localparam int HYPHEN_BIT = 1;
    localparam int SLASH_BIT_A = 2;
    localparam int SLASH_BIT_B = 6;
    localparam int SLASH_BIT_C = 7;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_COUNT = 4'hC;

    // control bits
    localparam int CTRL_SUBST_EN = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // status and mask bits
    localparam int EV_W = 4;
    localparam int EV_LRC = 0;
    localparam int EV_OVF = 1;
    localparam int EV_RCV = 2;
    localparam int EV_CASE = 3;
    localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // print selection magnets
    typedef struct packed {
        logic tilt_select_two;
        logic rotate_select_one;
        logic rotate_select_two;
        logic rotate_select_two_aux;
        logic rotate_select_five;
        logic shift_inhibit;
    } espsub_sel_t;

    // error detector inputs
    typedef struct packed {
        logic lrc_err;
        logic ovf_err;
        logic rcv_err;
        logic case_err;
    } espsub_err_t;

endpackage : espsub_pkg

// *** core/espsub_top.sv ***
// espsub_top: error-mark print substitute with AXI4-Lite registers
// assumes error pulses and buffer code come from logic on ref_clk
//
// Overview of operation
// - incorrect-case error prints slash via tilt two and rotates one, two, two-aux, five.
// - baseline marking sets the hyphen code bit of the second character buffer.
// - early errors clear hyphen bit and set slash bits a, b, c in the buffer.
// - late case error drives slash selections into print decoding and inhibits shifting.
`timescale 1ns/1ps
module espsub_top
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // error detectors and buffer
    input wire espsub_pkg::espsub_err_t err_in,
    input wire logic mark_load,
    input wire logic [espsub_pkg::CODE_W-1:0] buf_in,
    input wire logic print_strobe,
    // toward print decoding
    output logic [espsub_pkg::CODE_W-1:0] second_char_buffer,
    output espsub_pkg::espsub_sel_t print_sel,
    output logic irq,
    // axi4-lite
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [3:0] s_awaddr,
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [3:0] s_araddr,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp
);

    typedef struct packed {
        logic [espsub_pkg::CODE_W-1:0] buf_code;
        espsub_pkg::espsub_sel_t sel;
        logic subst_en;
        logic [espsub_pkg::EV_W-1:0] status;
        logic [espsub_pkg::EV_W-1:0] mask;
        logic [15:0] mark_cnt;
        logic case_pending;
        logic irq;
        logic aw_got;
        logic awready;
        logic [3:0] aw_addr;
        logic w_got;
        logic wready;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } espsub_state_t;

    espsub_state_t st_ff;
    espsub_state_t nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [espsub_pkg::CODE_W-1:0] mark_code(input logic slash);
        logic [espsub_pkg::CODE_W-1:0] c;
        c = '0;
        if (slash)
        begin
            c[espsub_pkg::SLASH_BIT_A] = 1'b1;
            c[espsub_pkg::SLASH_BIT_B] = 1'b1;
            c[espsub_pkg::SLASH_BIT_C] = 1'b1;
        end
        else
        begin
            c[espsub_pkg::HYPHEN_BIT] = 1'b1;
        end
        return c;
    endfunction : mark_code

    ////////////////////////////////////////////////////////////////////////////
    logic early_err;
    logic [espsub_pkg::EV_W-1:0] ev;
    logic wr_fire;
    logic rd_fire;

    assign early_err = err_in.lrc_err | err_in.ovf_err | err_in.rcv_err;
    assign ev = {err_in.case_err, err_in.rcv_err, err_in.ovf_err, err_in.lrc_err};
    assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    assign rd_fire = s_arvalid && st_ff.arready;

    always_comb
    begin
        nxt_st = st_ff;
        // buffer path: error mark replaces the code, else mark_load loads buf_in, otherwise the code holds
        if (early_err)
        begin
            nxt_st.buf_code = mark_code(st_ff.subst_en);
        end
        else if (mark_load)
        begin
            nxt_st.buf_code = buf_in;
        end
        // late case error waits for the next print strobe
        if (err_in.case_err)
        begin
            nxt_st.case_pending = 1'b1;
        end
        nxt_st.sel = '0;
        if (print_strobe && (st_ff.case_pending || err_in.case_err))
        begin
            nxt_st.sel.tilt_select_two = st_ff.subst_en;
            nxt_st.sel.rotate_select_one = st_ff.subst_en;
            nxt_st.sel.rotate_select_two = st_ff.subst_en;
            nxt_st.sel.rotate_select_two_aux = st_ff.subst_en;
            nxt_st.sel.rotate_select_five = st_ff.subst_en;
            nxt_st.sel.shift_inhibit = 1'b1;
            nxt_st.case_pending = 1'b0;
        end
        if (early_err || err_in.case_err)
        begin
            nxt_st.mark_cnt = st_ff.mark_cnt + 16'h0001;
        end
        // write channel
        if (s_awvalid && !st_ff.aw_got)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_addr = s_awaddr;
        end
        if (s_wvalid && !st_ff.w_got)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_data = s_wdata;
            nxt_st.w_strb = s_wstrb;
        end
        if (wr_fire)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = espsub_pkg::RESP_OKAY;
            unique case (st_ff.aw_addr)
                espsub_pkg::OFS_CTRL:
                begin
                    if (st_ff.w_strb[0])
                    begin
                        nxt_st.subst_en = st_ff.w_data[espsub_pkg::CTRL_SUBST_EN];
                    end
                end
                espsub_pkg::OFS_MASK:
                begin
                    if (st_ff.w_strb[0])
                    begin
                        nxt_st.mask = st_ff.w_data[espsub_pkg::EV_W-1:0];
                    end
                end
                espsub_pkg::OFS_STATUS, espsub_pkg::OFS_COUNT: ;
                default: nxt_st.bresp = espsub_pkg::RESP_SLVERR;
            endcase
        end
        if (st_ff.bvalid && s_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        // read channel; reading status clears it, new events win
        nxt_st.arready = !st_ff.rvalid && !rd_fire;
        if (rd_fire)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = espsub_pkg::RESP_OKAY;
            nxt_st.rdata = '0;
            unique case (s_araddr)
                espsub_pkg::OFS_CTRL: nxt_st.rdata[espsub_pkg::CTRL_SUBST_EN] = st_ff.subst_en;
                espsub_pkg::OFS_STATUS:
                begin
                    nxt_st.rdata[espsub_pkg::EV_W-1:0] = st_ff.status;
                    nxt_st.status = '0;
                end
                espsub_pkg::OFS_MASK: nxt_st.rdata[espsub_pkg::EV_W-1:0] = st_ff.mask;
                espsub_pkg::OFS_COUNT: nxt_st.rdata[15:0] = st_ff.mark_cnt;
                default: nxt_st.rresp = espsub_pkg::RESP_SLVERR;
            endcase
        end
        if (st_ff.rvalid && s_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
        nxt_st.status = nxt_st.status | ev;
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
        // ready flags kept in flops so the bus outputs carry no logic
        nxt_st.awready = !nxt_st.aw_got;
        nxt_st.wready = !nxt_st.w_got;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.subst_en <= espsub_pkg::CTRL_RESET[espsub_pkg::CTRL_SUBST_EN];
            st_ff.mask <= espsub_pkg::MASK_RESET;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign second_char_buffer = st_ff.buf_code;
    assign print_sel = st_ff.sel;
    assign irq = st_ff.irq;
    assign s_awready = st_ff.awready;
    assign s_wready = st_ff.wready;
    assign s_bvalid = st_ff.bvalid;
    assign s_bresp = st_ff.bresp;
    assign s_arready = st_ff.arready;
    assign s_rvalid = st_ff.rvalid;
    assign s_rdata = st_ff.rdata;
    assign s_rresp = st_ff.rresp;

endmodule : espsub_top
